/* hw/lwdt_defs.svh */
// Offsets, field positions, reset values and keys of the lockable watchdog
// Behaviour
// - Lock operation blocks every later configuration write until unlock
// - Unlock operation makes configuration writes take effect again
// - Lock state readable: one while locked, zero while unlocked
// - While locked, enables, reset enable/disable and reload writes are ignored
// - Interrupt enable bit lets the timeout interrupt reach the processor
// - Raw and masked interrupt status are both readable
// - Interrupt status reads one when active, zero when not
// - Reload value is readable and loaded into counter at first zero
// - Reload write while running loads the counter at once
// - Reload write of zero raises the timeout interrupt immediately
// - With reset enabled, second timeout drives system reset
// - With reset disabled, second timeout produces no system reset
// - Running indication reads true once counter enabled, else false
// - With stall enabled, counting stops while processor is debug halted
// - Counting resumes after halt; expiry needs full count of running cycles
// - Timing element is a 32-bit down counter loaded from reload register
// - Enable also enables interrupt; first zero raises it, reloads, counts on
// - Second zero with interrupt uncleared and reset enabled asserts reset
// - Interrupt clear before second timeout reloads counter and resumes
`ifndef LWDT_DEFS_SVH
`define LWDT_DEFS_SVH

`define LWDT_OFS_LOAD 12'h000
`define LWDT_OFS_VALUE 12'h004
`define LWDT_OFS_CTRL 12'h008
`define LWDT_OFS_ICR 12'h00C
`define LWDT_OFS_RIS 12'h010
`define LWDT_OFS_MIS 12'h014
`define LWDT_OFS_LOCK 12'h018
`define LWDT_OFS_STAT 12'h01C

`define LWDT_CTRL_RUN 0
`define LWDT_CTRL_INTEN 1
`define LWDT_CTRL_RSTEN 2
`define LWDT_CTRL_STALL 3
`define LWDT_STAT_LOCKED 0
`define LWDT_STAT_RUNNING 1

`define LWDT_LOAD_RST 32'hFFFFFFFF
// Arbitrary unlock key
`define LWDT_UNLOCK_KEY 32'h5A5AC0DE

`endif

/* hw/lwdt_pkg.sv */
// Types and register decode shared by the lockable watchdog
`include "lwdt_defs.svh"
package lwdt_pkg;
    typedef enum {
        LWDT_R_LOAD, LWDT_R_VALUE, LWDT_R_CTRL, LWDT_R_ICR,
        LWDT_R_RIS, LWDT_R_MIS, LWDT_R_LOCK, LWDT_R_STAT, LWDT_R_NONE
    } lwdt_reg_e;

    function automatic lwdt_reg_e lwdt_decode(input logic [11:0] addr);
        case (addr)
            `LWDT_OFS_LOAD: lwdt_decode = LWDT_R_LOAD;
            `LWDT_OFS_VALUE: lwdt_decode = LWDT_R_VALUE;
            `LWDT_OFS_CTRL: lwdt_decode = LWDT_R_CTRL;
            `LWDT_OFS_ICR: lwdt_decode = LWDT_R_ICR;
            `LWDT_OFS_RIS: lwdt_decode = LWDT_R_RIS;
            `LWDT_OFS_MIS: lwdt_decode = LWDT_R_MIS;
            `LWDT_OFS_LOCK: lwdt_decode = LWDT_R_LOCK;
            `LWDT_OFS_STAT: lwdt_decode = LWDT_R_STAT;
            default: lwdt_decode = LWDT_R_NONE;
        endcase
    endfunction : lwdt_decode
endpackage : lwdt_pkg

/* hw/lwdt_counter.sv */
// Loadable down counter that is the watchdog's timing element
`timescale 1ns/1ps
`include "lwdt_defs.svh"
module lwdt_counter #(
    parameter int WIDTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic dec_en,
    output logic [WIDTH-1:0] count,
    output logic at_zero
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_val;
        end else if (dec_en && (count_q != '0)) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= WIDTH'(`LWDT_LOAD_RST);
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;
    assign at_zero = (count_q == '0);
endmodule : lwdt_counter

/* hw/lwdt_apb_port.sv */
// APB phase decode: write strobe, read setup strobe and access handshake
`timescale 1ns/1ps
module lwdt_apb_port (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    output logic wr_stb,
    output logic rd_setup,
    output logic pready
);
    // Zero wait states: reads are captured in setup, so access ends at once
    assign pready = psel & penable;
    assign wr_stb = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
endmodule : lwdt_apb_port

/* hw/lwdt_top.sv */
// Lockable watchdog timer with an APB register slave
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "lwdt_defs.svh"
module lwdt_top
    import lwdt_pkg::*;
#(
    parameter int CNT_WIDTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic dbg_halt,
    output logic wdt_irq,
    output logic sys_rst_req,
    output logic wdt_running,
    output logic wdt_locked
);

    // Bus phase strobes
    logic wr_stb;
    logic rd_setup;

    lwdt_apb_port u_port (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .wr_stb(wr_stb),
        .rd_setup(rd_setup),
        .pready(pready)
    );

    lwdt_reg_e wr_reg;
    lwdt_reg_e rd_reg;

    assign wr_reg = lwdt_decode(paddr);
    assign rd_reg = lwdt_decode(paddr);

    // Configuration and status state
    logic locked_q;
    logic locked_d;
    logic run_q;
    logic run_d;
    logic inten_q;
    logic inten_d;
    logic rsten_q;
    logic rsten_d;
    logic stall_q;
    logic stall_d;
    logic [CNT_WIDTH-1:0] reload_q;
    logic [CNT_WIDTH-1:0] reload_d;
    logic raw_q;
    logic raw_d;
    logic sysrst_q;
    logic sysrst_d;
    logic irq_q;
    logic irq_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;

    // Counter hookup
    logic cnt_load;
    logic [CNT_WIDTH-1:0] cnt_load_val;
    logic cnt_dec;
    logic [CNT_WIDTH-1:0] cnt_value;
    logic cnt_zero;

    lwdt_counter #(
        .WIDTH(CNT_WIDTH)
    ) u_cnt (
        .mclk(mclk),
        .rst(rst),
        .load(cnt_load),
        .load_val(cnt_load_val),
        .dec_en(cnt_dec),
        .count(cnt_value),
        .at_zero(cnt_zero)
    );

    // Write qualifiers
    logic cfg_wr_ok;
    logic wr_load;
    logic wr_ctrl;
    logic wr_icr;
    logic wr_lock;
    logic run_start;
    logic timeout;

    always_comb begin
        cfg_wr_ok = wr_stb & ~locked_q;
        wr_load = cfg_wr_ok & (wr_reg == LWDT_R_LOAD);
        wr_ctrl = cfg_wr_ok & (wr_reg == LWDT_R_CTRL);
        // Clearing the interrupt is not configuration, so the lock leaves it open
        wr_icr = wr_stb & (wr_reg == LWDT_R_ICR);
        wr_lock = wr_stb & (wr_reg == LWDT_R_LOCK);
        run_start = wr_ctrl & pwdata[`LWDT_CTRL_RUN] & ~run_q;
    end

    // Stall only while debug halt and stall enable are both up
    always_comb begin
        cnt_dec = run_q & ~(stall_q & dbg_halt);
        timeout = cnt_dec & cnt_zero;
    end

    // Counter load sources; a fresh reload word wins over the stored one
    always_comb begin
        cnt_load = 1'b0;
        cnt_load_val = reload_q;
        if (wr_load && (run_q || run_start)) begin
            cnt_load = 1'b1;
            cnt_load_val = pwdata[CNT_WIDTH-1:0];
        end else if (run_start) begin
            cnt_load = 1'b1;
        end else if (timeout) begin
            cnt_load = 1'b1;
        end else if (wr_icr && run_q) begin
            cnt_load = 1'b1;
        end
    end

    // Configuration next state
    always_comb begin
        locked_d = locked_q;
        run_d = run_q;
        inten_d = inten_q;
        rsten_d = rsten_q;
        stall_d = stall_q;
        reload_d = reload_q;
        if (wr_lock) begin
            // Any word but the key locks; the key unlocks
            locked_d = (pwdata != `LWDT_UNLOCK_KEY);
        end
        if (wr_load) begin
            reload_d = pwdata[CNT_WIDTH-1:0];
        end
        if (wr_ctrl) begin
            // Run, interrupt and stall enables are set-only so runaway code cannot stop the watchdog; reset enable follows each write
            if (pwdata[`LWDT_CTRL_RUN]) begin
                run_d = 1'b1;
                inten_d = 1'b1;
            end
            if (pwdata[`LWDT_CTRL_INTEN]) begin
                inten_d = 1'b1;
            end
            rsten_d = pwdata[`LWDT_CTRL_RSTEN];
            if (pwdata[`LWDT_CTRL_STALL]) begin
                stall_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            locked_q <= 1'b0;
            run_q <= 1'b0;
            inten_q <= 1'b0;
            rsten_q <= 1'b0;
            stall_q <= 1'b0;
            reload_q <= CNT_WIDTH'(`LWDT_LOAD_RST);
        end else begin
            locked_q <= locked_d;
            run_q <= run_d;
            inten_q <= inten_d;
            rsten_q <= rsten_d;
            stall_q <= stall_d;
            reload_q <= reload_d;
        end
    end

    // Interrupt and system reset next state
    always_comb begin
        raw_d = raw_q;
        sysrst_d = sysrst_q;
        if (wr_icr) begin
            raw_d = 1'b0;
        end
        if (timeout && raw_q && rsten_q) begin
            sysrst_d = 1'b1;
        end
        // Setting after the clear keeps an event in the clear cycle
        if (timeout) begin
            raw_d = 1'b1;
        end
        if (wr_load && (pwdata[CNT_WIDTH-1:0] == '0)) begin
            raw_d = 1'b1;
        end
        irq_d = raw_d & inten_d;
    end

    // The reset request holds until system reset takes the block down
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            raw_q <= 1'b0;
            sysrst_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
            sysrst_q <= sysrst_d;
            irq_q <= irq_d;
        end
    end

    // Read data is captured in the setup cycle, so VALUE is one cycle old
    always_comb begin
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (rd_setup) begin
            rdata_d = 32'h00000000;
            case (rd_reg)
                LWDT_R_LOAD: begin
                    rdata_d[CNT_WIDTH-1:0] = reload_q;
                end
                LWDT_R_VALUE: begin
                    rdata_d[CNT_WIDTH-1:0] = cnt_value;
                end
                LWDT_R_CTRL: begin
                    rdata_d[`LWDT_CTRL_RUN] = run_q;
                    rdata_d[`LWDT_CTRL_INTEN] = inten_q;
                    rdata_d[`LWDT_CTRL_RSTEN] = rsten_q;
                    rdata_d[`LWDT_CTRL_STALL] = stall_q;
                end
                LWDT_R_ICR: begin
                    rdata_d = 32'h00000000;
                end
                LWDT_R_RIS: begin
                    rdata_d[0] = raw_q;
                end
                LWDT_R_MIS: begin
                    rdata_d[0] = raw_q & inten_q;
                end
                LWDT_R_LOCK: begin
                    rdata_d[0] = locked_q;
                end
                LWDT_R_STAT: begin
                    rdata_d[`LWDT_STAT_LOCKED] = locked_q;
                    rdata_d[`LWDT_STAT_RUNNING] = run_q;
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
        // Unmapped addresses answer with an error in their access phase
        if (psel && (rd_reg == LWDT_R_NONE)) begin
            err_d = ~penable;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pslverr = err_q & psel & penable;
    assign wdt_irq = irq_q;
    assign sys_rst_req = sysrst_q;
    assign wdt_running = run_q;
    assign wdt_locked = locked_q;
endmodule : lwdt_top

/* tb/lwdt_top_assertions.sv */
// Port-level checks of the lockable watchdog
`timescale 1ns/1ps
`include "lwdt_defs.svh"
module lwdt_top_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic wdt_irq,
    input wire logic sys_rst_req,
    input wire logic wdt_running,
    input wire logic wdt_locked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic acc;
    logic wr;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    a_lock_any: assert property (
        wr && paddr == `LWDT_OFS_LOCK && pwdata != `LWDT_UNLOCK_KEY |=> wdt_locked)
        else $error("lock not taken");
    a_unlock_key: assert property (
        wr && paddr == `LWDT_OFS_LOCK && pwdata == `LWDT_UNLOCK_KEY |=> !wdt_locked)
        else $error("unlock not taken");
    a_locked_norun: assert property (
        wr && paddr == `LWDT_OFS_CTRL && wdt_locked && !wdt_running |=> !wdt_running)
        else $error("locked enable took effect");
    a_run_start: assert property (
        wr && paddr == `LWDT_OFS_CTRL && !wdt_locked && pwdata[0] |=> wdt_running)
        else $error("enable not taken");
    a_run_stays: assert property (wdt_running |=> wdt_running)
        else $error("running dropped");
    a_zero_load: assert property (
        wr && paddr == `LWDT_OFS_LOAD && !wdt_locked && pwdata == 32'h0 && wdt_running
        |-> ##[1:3] wdt_irq) else $error("zero reload gave no interrupt");
    a_rst_sticky: assert property (sys_rst_req |=> sys_rst_req)
        else $error("system reset dropped");
    a_rst_running: assert property (sys_rst_req |-> wdt_running)
        else $error("system reset while stopped");
    a_stat_read: assert property (
        acc && !pwrite && paddr == `LWDT_OFS_STAT |-> prdata[1:0] == {wdt_running, wdt_locked})
        else $error("status read wrong");
endmodule : lwdt_top_assertions

bind lwdt_top lwdt_top_assertions u_chk (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .wdt_irq(wdt_irq), .sys_rst_req(sys_rst_req), .wdt_running(wdt_running),
    .wdt_locked(wdt_locked));

/* tb/lwdt_dbg_model.sv */
// Debug-halt source standing in for the processor core
`timescale 1ns/1ps
module lwdt_dbg_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic halt_cmd,
    output logic dbg_halt
);
    logic halt_q;
    logic halt_d;
    // Core enters halt a cycle after the request
    always_comb halt_d = halt_cmd;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) halt_q <= 1'b0;
        else halt_q <= halt_d;
    end
    assign dbg_halt = halt_q;
endmodule : lwdt_dbg_model

/* tb/lwdt_top_tb_top.sv */
// Self-checking bench for the lockable watchdog
`timescale 1ns/1ps
`include "lwdt_defs.svh"
module lwdt_top_tb_top;
    logic mclk, rst, psel, penable, pwrite, dbg_halt, halt_cmd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ld;
    logic pready, pslverr, wdt_irq, sys_rst_req, wdt_running, wdt_locked;
    logic [32:0] exp_q[$];
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    lwdt_top uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .dbg_halt(dbg_halt), .wdt_irq(wdt_irq), .sys_rst_req(sys_rst_req),
        .wdt_running(wdt_running), .wdt_locked(wdt_locked));
    lwdt_dbg_model u_dbg (.mclk(mclk), .rst(rst), .halt_cmd(halt_cmd), .dbg_halt(dbg_halt));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        if (t >= 16) begin
            miscompares++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // Expected word carries pslverr on top
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk({pslverr, prdata}, exp_q.pop_front());
        end
    end
    task automatic wait_for(input logic on_rst, input int lim);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((on_rst ? sys_rst_req : wdt_irq) !== 1'b1 && n < lim);
        if (n >= lim) begin
            miscompares++;
            complete_run();
        end
    endtask : wait_for
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset
    task automatic arm(input logic [31:0] c);
        wr(`LWDT_OFS_LOAD, ld);
        wr(`LWDT_OFS_CTRL, c);
    endtask : arm
    initial begin
        {rst, psel, penable, pwrite, halt_cmd} = 5'h10;
        paddr = 12'h0;
        pwdata = 32'h0;
        n = $urandom(32'h23B72E71);
        // Reload kept long enough that a clear lands before the second timeout
        ld = 32'h10 + ($urandom % 32);
        do_reset();
        rd(`LWDT_OFS_STAT, 33'h0);
        rd(`LWDT_OFS_LOAD, 33'h0FFFFFFFF);
        rd(12'h020, 33'h100000000);
        wr(`LWDT_OFS_LOCK, 32'h0);
        wr(`LWDT_OFS_CTRL, 32'h1);
        rd(`LWDT_OFS_STAT, 33'h1);
        wr(`LWDT_OFS_LOCK, `LWDT_UNLOCK_KEY);
        rd(`LWDT_OFS_STAT, 33'h0);
        $display("reset values done");
        arm(32'h1);
        wait_for(1'b0, 200);
        chk(33'(n), 33'(ld + 2));
        rd(`LWDT_OFS_RIS, 33'h1);
        rd(`LWDT_OFS_MIS, 33'h1);
        rd(`LWDT_OFS_STAT, 33'h2);
        wr(`LWDT_OFS_ICR, 32'h0);
        rd(`LWDT_OFS_RIS, 33'h0);
        wait_for(1'b0, 200);
        chk(33'(n), 33'(ld - 1));
        wr(`LWDT_OFS_CTRL, 32'h5);
        wait_for(1'b1, 200);
        chk(33'(n), 33'(ld - 2));
        $display("timeout and reset done");
        do_reset();
        arm(32'h5);
        wr(`LWDT_OFS_CTRL, 32'h1);
        wr(`LWDT_OFS_LOCK, $urandom | 32'h1);
        rd(`LWDT_OFS_LOCK, 33'h1);
        wr(`LWDT_OFS_LOAD, 32'h1234);
        wr(`LWDT_OFS_CTRL, 32'h4);
        rd(`LWDT_OFS_LOAD, {1'b0, ld});
        repeat (3 * ld + 10) @(posedge mclk);
        chk({sys_rst_req, wdt_irq}, 33'h1);
        wr(`LWDT_OFS_LOCK, `LWDT_UNLOCK_KEY);
        rd(`LWDT_OFS_STAT, 33'h2);
        wr(`LWDT_OFS_ICR, 32'h0);
        // Second clear: the first may meet a timeout, and the set wins
        wr(`LWDT_OFS_ICR, 32'h0);
        rd(`LWDT_OFS_RIS, 33'h0);
        wr(`LWDT_OFS_LOAD, 32'h0);
        wait_for(1'b0, 4);
        chk(33'(n), 33'h1);
        rd(`LWDT_OFS_VALUE, 33'h0);
        $display("lock and reload done");
        do_reset();
        arm(32'h9);
        halt_cmd <= 1'b1;
        repeat (3 * ld) @(posedge mclk);
        chk(wdt_irq, 33'h0);
        rd(`LWDT_OFS_VALUE, {1'b0, ld - 32'h1});
        rd(`LWDT_OFS_CTRL, 33'hB);
        halt_cmd <= 1'b0;
        wait_for(1'b0, 200);
        chk(33'(n), 33'(ld + 2));
        $display("debug stall done");
        complete_run();
    end
endmodule : lwdt_top_tb_top
